// File: include/hires_out_pkg.sv
// Constants, field layouts and carrier types for the high-rate output formatter.
// Assumes a 32-bit register port in the system clock domain and a recovered
// link clock that also runs the converters feeding the source samples.
package hires_out_pkg;

    // ==========================================================
    // Widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int SAMPLE_W = 24;
    localparam int NUM_SRC = 4;
    localparam int NUM_SLOT = 8;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
    localparam logic [ADDR_W-1:0] CS_PRO_OFFSET = 4'h4;
    localparam logic [ADDR_W-1:0] CS_CON_OFFSET = 4'h8;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'hc;

    // ==========================================================
    // Field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_PRO_BIT = 2;
    localparam int CTRL_NONAUDIO_BIT = 3;
    localparam int CS_FIELD_W = 6;
    localparam int STATUS_PENDING_BIT = 16;
    localparam int FRAME_COUNT_W = 16;

    // Channel-status byte 0 bit positions
    localparam int CS_PRO_BIT = 0;
    localparam int CS_NONAUDIO_BIT = 1;
    localparam int CS_BLOCK_FRAMES = 192;
    localparam int CS_BYTE0_BITS = 8;

    // ==========================================================
    // Reset values
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [CS_FIELD_W-1:0] CS_FIELD_RESET = 6'h00;
    localparam logic [7:0] BYTE0_RESET = 8'h00;

    // ==========================================================
    // Types
    typedef enum logic [1:0]
    {
        RATE_SINGLE = 2'b00,
        RATE_DOUBLE = 2'b01,
        RATE_QUAD = 2'b11
    } rate_mode_type;

    typedef logic [SAMPLE_W-1:0] sample_type;

    typedef struct packed
    {
        sample_type [NUM_SRC-1:0] ch;
    } src_samples_type;

    typedef struct packed
    {
        sample_type [NUM_SLOT-1:0] slot;
    } mc_frame_type;

    typedef struct packed
    {
        sample_type left;
        sample_type right;
        logic cs_bit;
        logic block_start;
    } stereo_frame_type;

    typedef struct packed
    {
        rate_mode_type mode;
        logic [7:0] byte0;
    } link_cfg_type;

endpackage

// File: src/hires_out_formatter.sv
// High-rate digital output formatter: multichannel slot multiplexing and
// stereo single-wire output with channel-status byte 0.
// Assumes source samples arrive on link_clk, the jitter-cleaned recovered
// clock, and software sits on clk behind a plain register port.
//
// Operation
// - Quad rate: source 1 slots 1-4, source 2 slots 5-8
// - Multichannel frames stay at base rate
// - Stereo output carries full rate, single wire
// - Byte 0 bit 0 selects professional or consumer
// - Audio positions identical in both formats
// - Byte 0 field layout per selected format
// - Recovered clean clock drives the multichannel and stereo outputs
// - Double rate: sources 1-4 into slot pairs
`timescale 1ns/1ps
`default_nettype none

module hires_out_formatter
(
    // System clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire logic [hires_out_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [hires_out_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [hires_out_pkg::DATA_W-1:0] reg_rdata,
    // Recovered link clock and source samples
    input wire logic link_clk,
    input wire logic src_strobe,
    input wire hires_out_pkg::src_samples_type src,
    // Multichannel optical output
    output logic mc_strobe,
    output hires_out_pkg::mc_frame_type mc_frame,
    // Stereo output
    output logic st_strobe,
    output hires_out_pkg::stereo_frame_type st_out
);
    import hires_out_pkg::*;

    // ==========================================================
    // Register file (clk domain)
    rate_mode_type ctrl_mode;
    logic ctrl_pro;
    logic ctrl_nonaudio;
    logic [CS_FIELD_W-1:0] pro_fields;
    logic [CS_FIELD_W-1:0] con_fields;
    logic [7:0] next_byte0;
    link_cfg_type cfg_word;
    logic cfg_req;
    logic cfg_dirty;
    logic ack_s1;
    logic ack_s2;
    logic frm_s1;
    logic frm_s2;
    logic frm_s3;
    logic [FRAME_COUNT_W-1:0] frame_count;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_mode <= RATE_SINGLE;
            ctrl_pro <= 1'b0;
            ctrl_nonaudio <= 1'b0;
            pro_fields <= CS_FIELD_RESET;
            con_fields <= CS_FIELD_RESET;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                CTRL_OFFSET:
                begin
                    case (reg_wdata[CTRL_MODE_LSB +: 2])
                        RATE_DOUBLE: ctrl_mode <= RATE_DOUBLE;
                        RATE_QUAD: ctrl_mode <= RATE_QUAD;
                        default: ctrl_mode <= RATE_SINGLE;
                    endcase
                    ctrl_pro <= reg_wdata[CTRL_PRO_BIT];
                    ctrl_nonaudio <= reg_wdata[CTRL_NONAUDIO_BIT];
                end
                CS_PRO_OFFSET: pro_fields <= reg_wdata[CS_FIELD_W-1:0];
                CS_CON_OFFSET: con_fields <= reg_wdata[CS_FIELD_W-1:0];
                default: ;
            endcase
        end
    end

    // Byte 0 assembly: bit 0 picks whether bits 2-7 come from pro_fields or con_fields; bit 1 is non-audio in both
    always_comb
    begin
        if (ctrl_pro)
            next_byte0 = {pro_fields[5:4], pro_fields[3], pro_fields[2:0],
                          ctrl_nonaudio, 1'b1};
        else
            next_byte0 = {con_fields[5:4], con_fields[3:1], con_fields[0],
                          ctrl_nonaudio, 1'b0};
    end

    // A config write only marks the snapshot stale; it is taken a cycle later
    // from the updated registers once no toggle is in flight. A write on the send cycle keeps it stale.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cfg_dirty <= 1'b0;
        else if (reg_wr && (reg_addr == CTRL_OFFSET || reg_addr == CS_PRO_OFFSET
                            || reg_addr == CS_CON_OFFSET))
            cfg_dirty <= 1'b1;
        else if (cfg_req == ack_s2)
            cfg_dirty <= 1'b0;
    end

    // Word is held steady while its toggle crosses two flip-flops
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg_word <= '{mode: RATE_SINGLE, byte0: BYTE0_RESET};
            cfg_req <= 1'b0;
        end
        else if (cfg_dirty && cfg_req == ack_s2)
        begin
            cfg_word <= '{mode: ctrl_mode, byte0: next_byte0};
            cfg_req <= ~cfg_req;
        end
    end

    // Returning acknowledge and frame events from the link side
    logic link_frame_tgl;
    logic link_ack;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            frm_s1 <= 1'b0;
            frm_s2 <= 1'b0;
            frm_s3 <= 1'b0;
        end
        else
        begin
            ack_s1 <= link_ack;
            ack_s2 <= ack_s1;
            frm_s1 <= link_frame_tgl;
            frm_s2 <= frm_s1;
            frm_s3 <= frm_s2;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            frame_count <= '0;
        else if (frm_s2 ^ frm_s3)
            frame_count <= frame_count + 1'b1;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            case (reg_addr)
                CTRL_OFFSET: reg_rdata <= {28'h0, ctrl_nonaudio, ctrl_pro, ctrl_mode};
                CS_PRO_OFFSET: reg_rdata <= {26'h0, pro_fields};
                CS_CON_OFFSET: reg_rdata <= {26'h0, con_fields};
                STATUS_OFFSET: reg_rdata <= {15'h0, (cfg_req ^ ack_s2) | cfg_dirty, frame_count};
                default: reg_rdata <= '0;
            endcase
        end
        else
            reg_rdata <= '0;
    end

    // ==========================================================
    // Link domain: everything from here up to the checks runs on the recovered clock
    logic link_rst_s1;
    logic link_rst_n;
    logic req_s1;
    logic req_s2;
    link_cfg_type link_cfg;
    logic [1:0] phase;
    logic [1:0] last_phase;
    mc_frame_type acc;
    mc_frame_type next_acc;
    logic [7:0] cs_index;

    always_ff @(posedge link_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            link_rst_s1 <= 1'b0;
            link_rst_n <= 1'b0;
        end
        else
        begin
            link_rst_s1 <= 1'b1;
            link_rst_n <= link_rst_s1;
        end
    end

    always_ff @(posedge link_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            link_ack <= 1'b0;
            link_cfg <= '{mode: RATE_SINGLE, byte0: BYTE0_RESET};
        end
        else
        begin
            req_s1 <= cfg_req;
            req_s2 <= req_s1;
            link_ack <= req_s2;
            if (req_s2 ^ link_ack)
                link_cfg <= cfg_word;
        end
    end

    always_comb
    begin
        case (link_cfg.mode)
            RATE_QUAD: last_phase = 2'h3;
            RATE_DOUBLE: last_phase = 2'h1;
            default: last_phase = 2'h0;
        endcase
    end

    // Slot placement; single rate fills slots 1-4 and silences 5-8
    always_comb
    begin
        next_acc = acc;
        case (link_cfg.mode)
            RATE_QUAD:
            begin
                next_acc.slot[phase] = src.ch[0];
                next_acc.slot[3'(4 + phase)] = src.ch[1];
            end
            RATE_DOUBLE:
            begin
                for (int s = 0; s < NUM_SRC; s++)
                    next_acc.slot[3'(2 * s) + 3'(phase)] = src.ch[s];
            end
            default:
            begin
                for (int s = 0; s < NUM_SLOT; s++)
                    next_acc.slot[s] = (s < NUM_SRC) ? src.ch[s % NUM_SRC] : '0;
            end
        endcase
    end

    // A mode change restarts slot grouping so no frame mixes two modes
    always_ff @(posedge link_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            phase <= 2'h0;
            acc <= '0;
            mc_strobe <= 1'b0;
            mc_frame <= '0;
            link_frame_tgl <= 1'b0;
        end
        else
        begin
            mc_strobe <= 1'b0;
            if (req_s2 ^ link_ack)
            begin
                phase <= 2'h0;
                acc <= '0;
            end
            else if (src_strobe)
            begin
                acc <= next_acc;
                if (phase == last_phase)
                begin
                    phase <= 2'h0;
                    mc_strobe <= 1'b1;
                    mc_frame <= next_acc;
                    link_frame_tgl <= ~link_frame_tgl;
                end
                else
                    phase <= phase + 2'h1;
            end
        end
    end

    // Stereo output: every source sample period gives one full frame
    always_ff @(posedge link_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            st_strobe <= 1'b0;
            st_out <= '0;
            cs_index <= 8'h00;
        end
        else
        begin
            st_strobe <= src_strobe;
            if (src_strobe)
            begin
                st_out.left <= src.ch[0];
                st_out.right <= src.ch[1];
                st_out.cs_bit <= (cs_index < CS_BYTE0_BITS) ?
                                 link_cfg.byte0[cs_index[2:0]] : 1'b0;
                st_out.block_start <= (cs_index == 8'h00);
                cs_index <= (cs_index == 8'(CS_BLOCK_FRAMES - 1)) ?
                            8'h00 : cs_index + 8'h01;
            end
        end
    end

    // ==========================================================
    // Checks
    logic [2:0] strobes_since;

    always_ff @(posedge link_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
            strobes_since <= 3'h0;
        else if (req_s2 ^ link_ack)
            strobes_since <= 3'h0;
        else if (mc_strobe)
            strobes_since <= src_strobe ? 3'h1 : 3'h0;
        else if (src_strobe)
            strobes_since <= strobes_since + 3'h1;
    end

    property p_quad_slots;
        @(posedge link_clk) disable iff (!link_rst_n)
        (src_strobe && link_cfg.mode == RATE_QUAD && phase == 2'h3 && !(req_s2 ^ link_ack))
        |=> (mc_strobe && mc_frame.slot[3] == $past(src.ch[0])
             && mc_frame.slot[7] == $past(src.ch[1]));
    endproperty
    a_quad_slots: assert property (p_quad_slots)
        else $error("quad slot 4 or 8 does not hold the latest sample");

    property p_base_rate;
        @(posedge link_clk) disable iff (!link_rst_n)
        (mc_strobe && link_cfg.mode == RATE_QUAD) |-> (strobes_since == 3'h4);
    endproperty
    a_base_rate: assert property (p_base_rate)
        else $error("multichannel frame not at one quarter of source rate");

    property p_single_wire;
        @(posedge link_clk) disable iff (!link_rst_n)
        src_strobe |=> st_strobe ##0 (st_out.left == $past(src.ch[0])
                                       && st_out.right == $past(src.ch[1]));
    endproperty
    a_single_wire: assert property (p_single_wire)
        else $error("stereo output did not carry both channels at full rate");

    property p_pro_bit;
        @(posedge link_clk) disable iff (!link_rst_n)
        (st_strobe && st_out.block_start) |-> (st_out.cs_bit == link_cfg.byte0[CS_PRO_BIT]
                                               || $past(req_s2 ^ link_ack));
    endproperty
    a_pro_bit: assert property (p_pro_bit)
        else $error("block start does not carry the format bit");

    property p_audio_same;
        @(posedge link_clk) disable iff (!link_rst_n)
        (src_strobe ##1 src_strobe) |=> (st_out.left == $past(src.ch[0]) && st_strobe);
    endproperty
    a_audio_same: assert property (p_audio_same)
        else $error("audio position moved with channel-status format");

    property p_byte0_layout;
        @(posedge clk) disable iff (!arst_n)
        ctrl_pro |-> (next_byte0[5] == pro_fields[3] && next_byte0[7:6] == pro_fields[5:4]
                      && next_byte0[CS_NONAUDIO_BIT] == ctrl_nonaudio);
    endproperty
    a_byte0_layout: assert property (p_byte0_layout)
        else $error("professional byte 0 fields misplaced");

    property p_double_slots;
        @(posedge link_clk) disable iff (!link_rst_n)
        (src_strobe && link_cfg.mode == RATE_DOUBLE && phase == 2'h1 && !(req_s2 ^ link_ack))
        |=> (mc_strobe && mc_frame.slot[1] == $past(src.ch[0])
             && mc_frame.slot[7] == $past(src.ch[3]));
    endproperty
    a_double_slots: assert property (p_double_slots)
        else $error("double rate slot pair mismatch");

    property p_time_order;
        @(posedge link_clk) disable iff (!link_rst_n)
        (src_strobe && link_cfg.mode == RATE_QUAD && phase == 2'h0 && !(req_s2 ^ link_ack))
        |=> (acc.slot[0] == $past(src.ch[0]) && acc.slot[4] == $past(src.ch[1]));
    endproperty
    a_time_order: assert property (p_time_order)
        else $error("first sample of a group not in the lowest slot");

    property p_read_latency;
        @(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr == CTRL_OFFSET)
        |=> reg_rdata == {28'h0, $past(ctrl_nonaudio), $past(ctrl_pro), $past(ctrl_mode)};
    endproperty
    a_read_latency: assert property (p_read_latency)
        else $error("read data not presented the cycle after the strobe");

    c_quad_frame: cover property (@(posedge link_clk) disable iff (!link_rst_n)
        mc_strobe && link_cfg.mode == RATE_QUAD);
    c_double_frame: cover property (@(posedge link_clk) disable iff (!link_rst_n)
        mc_strobe && link_cfg.mode == RATE_DOUBLE);
    c_pro_block: cover property (@(posedge link_clk) disable iff (!link_rst_n)
        st_strobe && st_out.block_start && st_out.cs_bit);
    c_cfg_applied: cover property (@(posedge clk) disable iff (!arst_n)
        $fell(cfg_req ^ ack_s2));

endmodule

`default_nettype wire

// File: testbench/quad_rate_smux_channel_status_test.sv
// Testbench for the high-rate output formatter: registers, slot
// multiplexing per rate mode and stereo channel status.
// Assumes the package and the receiver model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module quad_rate_smux_channel_status_test;
    import hires_out_pkg::*;

    logic clk;
    logic link_clk;
    logic arst_n;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic src_strobe;
    src_samples_type src;
    logic mc_strobe;
    mc_frame_type mc_frame;
    logic st_strobe;
    stereo_frame_type st_out;
    logic byte0_done;
    logic [7:0] byte0;
    logic is_pro;
    logic rd_chk;
    logic rd_due;
    logic [31:0] seed;
    logic [31:0] last_rd;
    int n_errors;
    int n_checks;
    int n_frames;
    logic [31:0] exp_rd[$];
    mc_frame_type exp_mc[$];
    logic [47:0] exp_lr[$];
    logic [7:0] exp_b0[$];

    hires_out_formatter uut
    (
        .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_clk(link_clk),
        .src_strobe(src_strobe), .src(src), .mc_strobe(mc_strobe), .mc_frame(mc_frame),
        .st_strobe(st_strobe), .st_out(st_out)
    );

    stereo_rx_model rx
    (
        .link_clk(link_clk), .arst_n(arst_n), .st_strobe(st_strobe), .st_out(st_out),
        .byte0_done(byte0_done), .byte0(byte0), .is_pro(is_pro)
    );

    // ==========================================================
    // Clocks
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Recovered clock runs free, phase unrelated to clk
    initial
    begin
        link_clk = 1'b0;
        #13;
        forever #40 link_clk = ~link_clk;
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input string what, input logic [191:0] seen, input logic [191:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic chk, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        rd_chk <= chk;
        if (chk)
            exp_rd.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        last_rd = reg_rdata;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        // A config write while one is in flight stays stale and is resent later, so wait it out
        for (i = 0; i < 60; i++)
        begin
            rd(STATUS_OFFSET, 1'b0, 32'h0);
            if (last_rd[STATUS_PENDING_BIT] === 1'b0)
                break;
        end
        if (i == 60)
        begin
            n_errors++;
            print_verdict();
        end
    endtask

    task automatic send_group(input rate_mode_type m, input int n);
        src_samples_type s;
        mc_frame_type f;
        logic [31:0] r;
        f = '0;
        for (int k = 0; k < n; k++)
        begin
            for (int c = 0; c < NUM_SRC; c++)
            begin
                r = xs();
                s.ch[c] = r[SAMPLE_W-1:0];
                if (m == RATE_QUAD && c < 2)
                    f.slot[4*c+k] = s.ch[c];
                else if (m == RATE_DOUBLE)
                    f.slot[2*c+k] = s.ch[c];
                else if (m != RATE_QUAD)
                    f.slot[c] = s.ch[c];
            end
            @(posedge link_clk);
            src_strobe <= 1'b1;
            src <= s;
            exp_lr.push_back({s.ch[0], s.ch[1]});
            r = xs();
            if (r[0])
            begin
                @(posedge link_clk);
                src_strobe <= 1'b0;
            end
        end
        exp_mc.push_back(f);
        n_frames++;
        @(posedge link_clk);
        src_strobe <= 1'b0;
    endtask

    // ==========================================================
    // Output watchers
    always @(posedge clk)
        rd_due <= reg_rd & rd_chk;

    always @(negedge clk)
    begin
        if (rd_due && exp_rd.size() > 0)
            check("rdata", reg_rdata, exp_rd.pop_front());
    end

    always @(negedge link_clk)
    begin
        if (mc_strobe && exp_mc.size() == 0)
            check("mc_extra", 1, 0);
        else if (mc_strobe)
            check("mc_frame", mc_frame, exp_mc.pop_front());
        if (st_strobe && exp_lr.size() == 0)
            check("st_extra", 1, 0);
        else if (st_strobe)
            check("st_audio", {st_out.left, st_out.right}, exp_lr.pop_front());
        if (byte0_done && exp_b0.size() > 0)
        begin
            check("is_pro", is_pro, exp_b0[0][CS_PRO_BIT]);
            check("byte0", byte0, exp_b0.pop_front());
        end
    end

    initial
    begin
        repeat (100000) @(posedge clk);
        n_errors++;
        print_verdict();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        rate_mode_type mode_tbl[4];
        logic [31:0] r;
        logic pro;
        int n;
        mode_tbl = '{RATE_SINGLE, RATE_DOUBLE, RATE_QUAD, RATE_QUAD};
        seed = 32'h0000a36d;
        arst_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rd_chk = 1'b0;
        src_strobe = 1'b0;
        src = '0;
        n_errors = 0;
        n_checks = 0;
        n_frames = 0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        // Reset values and an unmapped place
        rd(CTRL_OFFSET, 1'b1, 32'h0);
        rd(CS_PRO_OFFSET, 1'b1, 32'h0);
        rd(CS_CON_OFFSET, 1'b1, 32'h0);
        rd(4'h2, 1'b1, 32'h0);
        // The unused rate code falls back to single rate
        wr(CTRL_OFFSET, 32'h2);
        rd(CTRL_OFFSET, 1'b1, 32'h0);
        wr(STATUS_OFFSET, 32'hffffffff);
        rd(STATUS_OFFSET, 1'b1, 32'h0);
        $display("test registers done");
        for (int t = 0; t < 4; t++)
        begin
            r = xs();
            pro = t[0];
            wr(CS_PRO_OFFSET, {26'h0, r[5:0]});
            wr(CS_CON_OFFSET, {26'h0, r[11:6]});
            wr(CTRL_OFFSET, {28'h0, r[12], pro, mode_tbl[t]});
            rd(CTRL_OFFSET, 1'b1, {28'h0, r[12], pro, mode_tbl[t]});
            rd(CS_CON_OFFSET, 1'b1, {26'h0, r[11:6]});
            n = (mode_tbl[t] == RATE_QUAD) ? 4 : (mode_tbl[t] == RATE_DOUBLE) ? 2 : 1;
            // First block may mix old and new settings, so its byte 0 is not judged
            repeat (192 / n) send_group(mode_tbl[t], n);
            exp_b0.push_back({pro ? r[5:0] : r[11:6], r[12], pro});
            repeat (192 / n) send_group(mode_tbl[t], n);
            repeat (12) @(posedge link_clk);
            rd(STATUS_OFFSET, 1'b1, {16'h0, 16'(n_frames)});
            $display("test mode %0d done", t);
        end
        check("mc_left", exp_mc.size(), 0);
        check("st_left", exp_lr.size(), 0);
        check("b0_left", exp_b0.size(), 0);
        print_verdict();
    end
endmodule
`default_nettype wire

// File: testbench/stereo_rx_model.sv
// Receiver model at the stereo output: rebuilds channel-status byte 0.
// Assumes st_out and st_strobe come from the link clock domain.
`timescale 1ns/1ps
`default_nettype none

module stereo_rx_model
(
    // Link side
    input wire logic link_clk,
    input wire logic arst_n,
    input wire logic st_strobe,
    input wire hires_out_pkg::stereo_frame_type st_out,
    // Decoded channel status
    output logic byte0_done,
    output logic [7:0] byte0,
    output logic is_pro
);
    import hires_out_pkg::*;

    int idx;
    logic [7:0] acc;

    // ==========================================================
    // Block tracking
    // Frame index restarts on the block marker; only bits 0..7 carry data
    always @(posedge link_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            idx = CS_BLOCK_FRAMES;
            acc = 8'h00;
            byte0_done <= 1'b0;
            byte0 <= 8'h00;
            is_pro <= 1'b0;
        end
        else
        begin
            byte0_done <= 1'b0;
            if (st_strobe)
            begin
                idx = st_out.block_start ? 0 : idx + 1;
                if (idx < CS_BYTE0_BITS)
                    acc[idx] = st_out.cs_bit;
                if (idx == CS_BYTE0_BITS - 1)
                begin
                    byte0_done <= 1'b1;
                    byte0 <= acc;
                    // Bit 0 tells which layout the later bits use; it is reported as is_pro
                    is_pro <= acc[CS_PRO_BIT];
                end
            end
        end
    end
endmodule
`default_nettype wire
